// [verilog/sbio_cfg.svh]
`ifndef SBIO_CFG_SVH
`define SBIO_CFG_SVH
`define SBIO_NPORT 3
`define SBIO_PORT_STRIDE 32'h0000_0020
`define SBIO_OFF_MODE 3'h0
`define SBIO_OFF_OUT 3'h1
`define SBIO_OFF_FLASH 3'h2
`define SBIO_OFF_IN 3'h3
`define SBIO_OFF_EDGE 3'h4
`define SBIO_OFF_EDGE_EN 3'h5
`define SBIO_OFF_GROUP 3'h6
`define SBIO_OFF_MIRROR 3'h7
`define SBIO_EDGE_RISE_LSB 0
`define SBIO_EDGE_FALL_LSB 8
`define SBIO_MIRROR_EN_LSB 0
`define SBIO_MIRROR_DRV_LSB 8
`define SBIO_GRP_PBC_BIT 0
`define SBIO_GRP_CRU_BIT 1
`define SBIO_GRP_SDU_BIT 2
`define SBIO_RST_MODE 16'h0000
`define SBIO_RST_OUT 8'h00
`define SBIO_RST_FLASH 16'h0000
`define SBIO_RST_EDGE_EN 16'h0000
`define SBIO_RST_GROUP 12'h000
`define SBIO_RST_MIRROR 12'h000
`define SBIO_FLASH_BIT0 24
`define SBIO_FLASH_CNT_W 28
`endif

// [verilog/sbio_pkg.sv]
package sbio_pkg;
   typedef enum logic [1:0] {
      SBIO_DRV_IN,
      SBIO_DRV_PP,
      SBIO_DRV_OD,
      SBIO_DRV_OS
   } sbio_drv_t;

   typedef struct packed {
      logic [15:0] mode;
      logic [7:0] out;
      logic [15:0] flash;
      logic [15:0] edge_en;
      logic [11:0] group;
      logic [3:0] mirror_drv_hi;
      logic [3:0] mirror_drv_lo;
      logic [3:0] mirror_en;
   } sbio_port_cfg_t;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } sbio_pins_t;
endpackage : sbio_pkg

// [verilog/sbio_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sbio_cfg.svh"
module sbio_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] pin_i,
   input wire sbio_pkg::sbio_port_cfg_t cfg,
   input wire logic [2:0] flash_tap,
   input wire logic [3:0] func_req,
   output sbio_pkg::sbio_pins_t pins_q,
   output logic [7:0] lvl_q,
   output logic [7:0] rise_q,
   output logic [7:0] fall_q,
   output logic [3:0] func_stat_q
);
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] s3_q;
   logic [7:0] is_in;
   sbio_pkg::sbio_pins_t pins_d;

   // two flops before any logic looks at the pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_comb begin
      sbio_pkg::sbio_drv_t drv;
      logic val;
      logic ded;
      drv = sbio_pkg::SBIO_DRV_IN;
      val = 1'b0;
      ded = 1'b0;
      pins_d = '0;
      is_in = 8'h00;
      for (int i = 0; i < 8; i++) begin
         ded = |cfg.group[(i/2)*3 +: 3];
         if (ded) begin
            // even pin drives the request, odd pin senses the status
            if (i % 2 == 0) begin
               drv = sbio_pkg::sbio_drv_t'(cfg.mode[2*i +: 2]);
               val = func_req[i/2];
            end else begin
               drv = sbio_pkg::SBIO_DRV_IN;
               val = 1'b0;
            end
         end else if ((i % 2 == 1) && cfg.mirror_en[i/2]) begin
            drv = sbio_pkg::sbio_drv_t'({cfg.mirror_drv_hi[i/2],
               cfg.mirror_drv_lo[i/2]});
            val = s2_q[i-1];
         end else begin
            drv = sbio_pkg::sbio_drv_t'(cfg.mode[2*i +: 2]);
            val = cfg.out[i];
            if (cfg.flash[2*i +: 2] != 2'b00) begin
               val = cfg.out[i] & flash_tap[cfg.flash[2*i +: 2] - 2'd1];
            end
         end
         case (drv)
            sbio_pkg::SBIO_DRV_IN: begin
               is_in[i] = 1'b1;
            end
            sbio_pkg::SBIO_DRV_PP: begin
               pins_d.o[i] = val;
               pins_d.oe[i] = 1'b1;
            end
            sbio_pkg::SBIO_DRV_OD: begin
               pins_d.o[i] = 1'b0;
               pins_d.oe[i] = ~val;
            end
            default: begin
               pins_d.o[i] = 1'b1;
               pins_d.oe[i] = val;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_q <= '0;
      end else begin
         pins_q <= pins_d;
      end
   end

   // only pins that are inputs report edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rise_q <= 8'h00;
         fall_q <= 8'h00;
      end else begin
         rise_q <= s2_q & ~s3_q & is_in &
            cfg.edge_en[`SBIO_EDGE_RISE_LSB +: 8];
         fall_q <= ~s2_q & s3_q & is_in &
            cfg.edge_en[`SBIO_EDGE_FALL_LSB +: 8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_q <= 8'h00;
         func_stat_q <= 4'h0;
      end else begin
         lvl_q <= s2_q;
         func_stat_q <= {s2_q[7], s2_q[5], s2_q[3], s2_q[1]};
      end
   end
endmodule : sbio_port
`default_nettype wire

// [verilog/sbio_top.sv]
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sbio_cfg.svh"
module sbio_top #(
   parameter int FLASH_BIT0 = `SBIO_FLASH_BIT0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [23:0] pin_i,
   output logic [23:0] pin_o,
   output logic [23:0] pin_oe,
   input wire logic [11:0] port_bypass_circuit_req,
   input wire logic [11:0] clock_recovery_unit_req,
   input wire logic [11:0] signal_detect_unit_req,
   output logic [11:0] func_status,
   output logic [23:0] edge_flag
);
   localparam int NP = `SBIO_NPORT;

   if (FLASH_BIT0 < 1 || FLASH_BIT0 + 2 >= `SBIO_FLASH_CNT_W) begin : g_chk
      $error("FLASH_BIT0 out of range");
   end

   sbio_pkg::sbio_port_cfg_t cfg_q [NP];
   logic [7:0] edge_q [NP];
   logic [7:0] lvl [NP];
   logic [7:0] rise [NP];
   logic [7:0] fall [NP];
   logic [`SBIO_FLASH_CNT_W-1:0] flash_cnt_q;
   logic [2:0] flash_tap;
   logic [1:0] sel_port;
   logic [2:0] sel_reg;
   logic mapped;
   logic wr_go;
   logic [31:0] rd_d;
   logic ready_q;
   logic [31:0] prdata_q;
   logic slverr_q;

   // one free-running counter feeds all three rates, each half the last
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_q <= '0;
      end else begin
         flash_cnt_q <= flash_cnt_q + 1'b1;
      end
   end
   assign flash_tap = flash_cnt_q[FLASH_BIT0 +: 3];

   assign sel_port = paddr[6:5];
   assign sel_reg = paddr[4:2];
   assign mapped = (paddr[31:7] == 25'h0) && (sel_port < 2'(NP));
   assign wr_go = psel & penable & ready_q & pwrite & mapped;

   // read mux; unmapped space reads zero
   always_comb begin
      sbio_pkg::sbio_port_cfg_t c;
      c = cfg_q[0];
      rd_d = 32'h0000_0000;
      if (mapped) begin
         c = cfg_q[sel_port];
         if (sel_reg == `SBIO_OFF_MODE) begin
            rd_d = {16'h0000, c.mode};
         end else if (sel_reg == `SBIO_OFF_OUT) begin
            rd_d = {24'h00_0000, c.out};
         end else if (sel_reg == `SBIO_OFF_FLASH) begin
            rd_d = {16'h0000, c.flash};
         end else if (sel_reg == `SBIO_OFF_IN) begin
            rd_d = {24'h00_0000, lvl[sel_port]};
         end else if (sel_reg == `SBIO_OFF_EDGE) begin
            rd_d = {24'h00_0000, edge_q[sel_port]};
         end else if (sel_reg == `SBIO_OFF_EDGE_EN) begin
            rd_d = {16'h0000, c.edge_en};
         end else if (sel_reg == `SBIO_OFF_GROUP) begin
            rd_d = {20'h0_0000, c.group};
         end else begin
            rd_d = {20'h0_0000, c.mirror_drv_hi, c.mirror_drv_lo,
               c.mirror_en};
         end
      end
   end

   // one wait-free access cycle; pready rises in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else begin
         ready_q <= psel & ~penable & ~ready_q;
         prdata_q <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0000_0000;
         slverr_q <= psel & ~penable & ~mapped;
      end
   end
   assign pready = ready_q;
   assign prdata = prdata_q;
   assign pslverr = slverr_q;

   for (genvar p = 0; p < NP; p++) begin : g_port
      logic [3:0] func_req;
      logic [3:0] stat;
      sbio_pkg::sbio_pins_t pins;
      logic hit;
      assign hit = wr_go && (sel_port == 2'(p));

      for (genvar g = 0; g < 4; g++) begin : g_grp
         assign func_req[g] =
            (cfg_q[p].group[g*3+`SBIO_GRP_PBC_BIT] &
             port_bypass_circuit_req[p*4+g]) |
            (cfg_q[p].group[g*3+`SBIO_GRP_CRU_BIT] &
             clock_recovery_unit_req[p*4+g]) |
            (cfg_q[p].group[g*3+`SBIO_GRP_SDU_BIT] &
             signal_detect_unit_req[p*4+g]);
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg_q[p].mode <= `SBIO_RST_MODE;
            cfg_q[p].out <= `SBIO_RST_OUT;
            cfg_q[p].flash <= `SBIO_RST_FLASH;
            cfg_q[p].edge_en <= `SBIO_RST_EDGE_EN;
            cfg_q[p].group <= `SBIO_RST_GROUP;
            {cfg_q[p].mirror_drv_hi, cfg_q[p].mirror_drv_lo,
               cfg_q[p].mirror_en} <= `SBIO_RST_MIRROR;
         end else if (hit) begin
            if (sel_reg == `SBIO_OFF_MODE) begin
               cfg_q[p].mode <= pwdata[15:0];
            end else if (sel_reg == `SBIO_OFF_OUT) begin
               cfg_q[p].out <= pwdata[7:0];
            end else if (sel_reg == `SBIO_OFF_FLASH) begin
               cfg_q[p].flash <= pwdata[15:0];
            end else if (sel_reg == `SBIO_OFF_EDGE_EN) begin
               cfg_q[p].edge_en <= pwdata[15:0];
            end else if (sel_reg == `SBIO_OFF_GROUP) begin
               cfg_q[p].group <= pwdata[11:0];
            end else if (sel_reg == `SBIO_OFF_MIRROR) begin
               {cfg_q[p].mirror_drv_hi, cfg_q[p].mirror_drv_lo,
                  cfg_q[p].mirror_en} <= pwdata[11:0];
            end
         end
      end

      // write one to clear; a new edge in the same cycle wins
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            edge_q[p] <= 8'h00;
         end else begin
            edge_q[p] <= (edge_q[p] &
               ~((hit && sel_reg == `SBIO_OFF_EDGE) ? pwdata[7:0] : 8'h00))
               | rise[p] | fall[p];
         end
      end

      sbio_port u_port (
         .pclk(pclk),
         .presetn(presetn),
         .pin_i(pin_i[p*8 +: 8]),
         .cfg(cfg_q[p]),
         .flash_tap(flash_tap),
         .func_req(func_req),
         .pins_q(pins),
         .lvl_q(lvl[p]),
         .rise_q(rise[p]),
         .fall_q(fall[p]),
         .func_stat_q(stat)
      );

      assign pin_o[p*8 +: 8] = pins.o;
      assign pin_oe[p*8 +: 8] = pins.oe;
      assign func_status[p*4 +: 4] = stat;
      assign edge_flag[p*8 +: 8] = edge_q[p];
   end
endmodule : sbio_top
`default_nettype wire

// [tb/sbio_ext.sv]
`timescale 1ns/10ps
`default_nettype none
module sbio_ext (
   input wire logic [23:0] pin_o,
   input wire logic [23:0] pin_oe,
   input wire logic [23:0] ext_v,
   input wire logic [23:0] ext_en,
   output logic [23:0] pin_i
);
   // released lines with ext_en low go to the pull-up, those with ext_en high take ext_v, never keep a stale level
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & (~ext_en | ext_v));
endmodule : sbio_ext
`default_nettype wire

// [tb/sbio_top_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module sbio_top_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [23:0] pin_i,
   input wire logic [23:0] edge_flag
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic bad_a;
   assign bad_a = (paddr[31:7] != 25'h0) || (paddr[6:5] == 2'h3);
   property p_setup_ready;
      psel && !penable |=> pready;
   endproperty
   a_setup_ready: assert property (p_setup_ready)
      else $error("no ready after setup");
   property p_ready_access;
      pready |-> psel && penable;
   endproperty
   a_ready_access: assert property (p_ready_access)
      else $error("ready outside access");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_err_decode;
      pready && bad_a |-> pslverr;
   endproperty
   a_err_decode: assert property (p_err_decode) else $error("bad address ok");
   property p_ok_decode;
      pready && !bad_a |-> !pslverr;
   endproperty
   a_ok_decode: assert property (p_ok_decode) else $error("good address error");
   property p_rdata_idle;
      !pready || pslverr |-> prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not 0");
   property p_flag_cause;
      (edge_flag & ~$past(edge_flag) & ~(($past(pin_i, 2) ^ $past(pin_i, 3))
         | ($past(pin_i, 3) ^ $past(pin_i, 4))
         | ($past(pin_i, 4) ^ $past(pin_i, 5)))) == 24'h0;
   endproperty
   a_flag_cause: assert property (p_flag_cause)
      else $error("flag set without pin change");
   property p_flag_clear;
      ($past(edge_flag) & ~edge_flag) != 24'h0
         |-> $past(psel && penable && pready && pwrite);
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag dropped without write");
endmodule : sbio_top_chk
bind sbio_top sbio_top_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .pin_i, .edge_flag);
`default_nettype wire

// [tb/sbio_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module sbio_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd_q;
   logic pready, pslverr, erq, pv;
   logic [23:0] pin_i, pin_o, pin_oe, edge_flag;
   logic [23:0] ext_v = 24'h0;
   logic [23:0] ext_en = 24'h010804;
   logic [11:0] bp_req = 12'h0;
   logic [11:0] cr_req = 12'h0;
   logic [11:0] sd_req = 12'h0;
   logic [11:0] func_status;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int tg;
   always #2 pclk = ~pclk;
   sbio_top #(.FLASH_BIT0(2)) dut_u (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o,
      .pin_oe, .port_bypass_circuit_req(bp_req),
      .clock_recovery_unit_req(cr_req), .signal_detect_unit_req(sd_req),
      .func_status, .edge_flag);
   sbio_ext ext_u (.pin_o, .pin_oe, .ext_v, .ext_en, .pin_i);
   task stop_test;
      if (n_fail == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // idle cycle first, so no strobe is driven twice in one step
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_q = prdata;
      erq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task rd(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd_q, e);
   endtask : rd
   task w(input int n);
      repeat (n) @(posedge pclk);
   endtask : w
   function logic [31:0] ad(input int p, input int r);
      ad = 32'(p * 32 + r * 4);
   endfunction : ad
   function logic [1:0] de(input int m, input logic v);
      case (m)
         1: de = {v, 1'b1};
         2: de = {1'b0, ~v};
         3: de = {1'b1, v};
         default: de = 2'h0;
      endcase
   endfunction : de
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(pin_oe), 32'h0);
      rd(ad(0, 0), 32'h0);
      for (int m = 0; m < 4; m++) begin
         for (int v = 0; v < 2; v++) begin
            wr(ad(1, 1), 32'(v));
            wr(ad(1, 0), 32'(m));
            w(2);
            chk(32'({pin_o[8], pin_oe[8]}), 32'(de(m, v[0])));
         end
      end
      wr(ad(0, 5), 32'h4);
      w(8);
      chk(32'(edge_flag), 32'h0);
      ext_v <= 24'h4;
      w(8);
      chk(32'(edge_flag), 32'h4);
      rd(ad(0, 4), 32'h4);
      ext_v <= 24'h0;
      w(8);
      chk(32'(edge_flag), 32'h4);
      wr(ad(0, 4), 32'h4);
      w(2);
      chk(32'(edge_flag), 32'h0);
      wr(ad(0, 5), 32'h400);
      ext_v <= 24'h4;
      w(8);
      chk(32'(edge_flag), 32'h0);
      ext_v <= 24'h800;
      w(8);
      chk(32'(edge_flag), 32'h4);
      wr(ad(1, 0), 32'h11);
      wr(ad(1, 1), 32'h1);
      wr(ad(1, 6), 32'h8);
      bp_req <= 12'h020;
      cr_req <= 12'h020;
      w(4);
      chk(32'({pin_o[10], pin_oe[10], pin_o[8], pin_oe[8]}), 32'hf);
      bp_req <= 12'h0;
      w(4);
      chk(32'({pin_o[10], pin_oe[10], pin_o[8], pin_oe[8]}), 32'h7);
      chk(32'(func_status[5]), 32'h1);
      wr(ad(1, 6), 32'h18);
      w(4);
      chk(32'({pin_o[10], pin_oe[10]}), 32'h3);
      wr(ad(1, 6), 32'h20);
      w(4);
      chk(32'({pin_o[10], pin_oe[10]}), 32'h1);
      sd_req <= 12'h020;
      w(4);
      chk(32'({pin_o[10], pin_oe[10]}), 32'h3);
      ext_v <= 24'h010800;
      wr(ad(2, 7), 32'h011);
      w(6);
      chk(32'({pin_o[17], pin_oe[17]}), 32'h3);
      ext_v <= 24'h000800;
      w(6);
      chk(32'({pin_o[17], pin_oe[17]}), 32'h1);
      wr(ad(2, 7), 32'h101);
      w(6);
      chk(32'({pin_o[17], pin_oe[17]}), 32'h1);
      ext_v <= 24'h010800;
      w(6);
      chk(32'({pin_o[17], pin_oe[17]}), 32'h0);
      wr(ad(2, 7), 32'h111);
      w(6);
      chk(32'({pin_o[17], pin_oe[17]}), 32'h3);
      wr(ad(0, 0), 32'h4000);
      wr(ad(0, 1), 32'h80);
      // 16 intervals hold exactly 16/half-period toggles, any phase
      for (int k = 1; k < 4; k++) begin
         wr(ad(0, 2), 32'(k << 14));
         w(2);
         pv = pin_o[7];
         tg = 0;
         repeat (16) begin
            @(posedge pclk);
            if (pin_o[7] !== pv) tg++;
            pv = pin_o[7];
         end
         chk(32'(tg), 32'(8 >> k));
      end
      wr(ad(2, 3), 32'h0);
      rd(ad(2, 3), 32'hff);
      rd(ad(1, 1), 32'h1);
      rd(32'h60, 32'h0);
      chk(32'(erq), 32'h1);
      rd(32'h80, 32'h0);
      chk(32'(erq), 32'h1);
      stop_test();
   end
endmodule : sbio_top_tb
`default_nettype wire
